/* lcdhc_params.svh */
// constants for the lcd host command front end
`ifndef LCDHC_PARAMS_SVH
`define LCDHC_PARAMS_SVH
`define LCDHC_CLK_MHZ 25
`define LCDHC_EXEC_NS 320
`define LCDHC_EXEC_CYC ((`LCDHC_EXEC_NS * `LCDHC_CLK_MHZ + 999) / 1000)
`define LCDHC_CNT_W 4
`define LCDHC_PIN_W 13
`define LCDHC_A_STATUS 8'h00
`define LCDHC_A_MODE 8'h04
`define LCDHC_A_CURSOR 8'h08
`define LCDHC_A_CTRL 8'h0c
`define LCDHC_A_START 8'h10
`define LCDHC_CL_CFG 3'h0
`define LCDHC_CL_POLL 3'h1
`define LCDHC_CL_WCUR 3'h2
`define LCDHC_CL_RCUR 3'h3
`define LCDHC_CL_WSTA 3'h4
`define LCDHC_CL_RSTA 3'h5
`define LCDHC_CL_WDAT 3'h6
`define LCDHC_CL_RDAT 3'h7
`define LCDHC_OP_FUNC 2'h3
`define LCDHC_OP_ENTRY 4'h4
`define LCDHC_OP_DISP 4'h3
`define LCDHC_OP_UL 4'h2
`define LCDHC_OP_BLINK 4'h1
`define LCDHC_OP_MOVE 5'h01
`define LCDHC_OP_MARK 6'h01
`define LCDHC_DEND0 8'hff
`define LCDHC_DEND1 8'hdf
`define LCDHC_DEND2 8'hbf
`define LCDHC_DEND3 8'h9f
`define LCDHC_RAM_TOP 8'hff
`define LCDHC_ADDR_ZERO 8'h00
`define LCDHC_MODE_RST 20'h80000
`endif

/* lcdhc_pkg.sv */
// types for the lcd host command front end
package lcdhc_pkg;
  typedef struct packed {
    logic host_type;
    logic sel_a;
    logic sel_b;
    logic rw;
    logic strobe;
    logic [7:0] bus;
  } lcdhc_pins_t;
  typedef struct packed {
    logic width8;
    logic font;
    logic [1:0] lines;
    logic [1:0] part;
    logic step_wr;
    logic step_rd;
    logic step_up;
    logic [3:0] disp;
    logic [1:0] ul_mode;
    logic [3:0] blink;
    logic spare;
  } lcdhc_mode_t;
  typedef enum logic [1:0] {
    LCDHC_IDLE = 2'b00,
    LCDHC_RUN = 2'b01
  } lcdhc_state_t;
endpackage

/* lcdhc_top.sv */
// lcd host command front end: host pins, decode, busy, mode, cursor, apb view
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "lcdhc_params.svh"
module lcdhc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire lcdhc_pkg::lcdhc_pins_t host_pins,
  output logic [7:0] host_bus_out,
  output logic [1:0] host_bus_oe,
  output logic busy,
  output lcdhc_pkg::lcdhc_mode_t mode,
  output logic [7:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic ram_ul_we,
  output logic ram_ul_bit,
  input wire logic [7:0] ram_rdata,
  output logic [7:0] disp_start,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import lcdhc_pkg::*;

  logic [`LCDHC_PIN_W-1:0] sync1_q;
  logic [`LCDHC_PIN_W-1:0] sync2_q;
  lcdhc_pins_t s;
  logic prev_strobe_q, prev_wr_q, prev_rd_q;
  logic nib_q;
  logic [3:0] hi_q;
  logic [7:0] addr_q;
  logic [10:0] instr_q;
  logic [7:0] in_q;
  logic [7:0] out_q;
  logic [7:0] rdata_q;
  logic [1:0] oe_q;
  logic busy_q, exec_q;
  logic [`LCDHC_CNT_W-1:0] cnt_q;
  lcdhc_state_t state_q;
  lcdhc_mode_t mode_q;
  logic [7:0] cursor_q, start_q;
  logic ram_we_q, ram_ul_we_q, ram_ul_bit_q;
  logic [7:0] ram_wdata_q;
  logic host_en_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  // asynchronous host pins: two flops, the first read by nothing else
  for (genvar i = 0; i < `LCDHC_PIN_W; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else if (ce) begin
        sync1_q[i] <= host_pins[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end
  assign s = lcdhc_pins_t'(sync2_q);

  logic mp, strobe_fall, wr_rise, rd_rise, ale_fall, uc_go, mp_go, go;
  logic [2:0] cls;
  logic [7:0] code;
  logic is_poll, accept;
  assign mp = s.host_type;
  assign strobe_fall = prev_strobe_q & ~s.strobe;
  assign ale_fall = strobe_fall;
  // muxed bus: write strobe on select a, read strobe on direction, io on select b
  assign wr_rise = ~prev_wr_q & s.sel_a & s.sel_b;
  assign rd_rise = ~prev_rd_q & s.rw & s.sel_b;
  assign uc_go = ~mp & strobe_fall & (mode_q.width8 | nib_q);
  assign mp_go = mp & (wr_rise | rd_rise);
  assign go = host_en_q & (uc_go | mp_go);
  // class: selects plus direction, or on the muxed bus latched address bits plus direction; direction 0 write and 1 read
  assign cls = mp ? {addr_q[1:0], rd_rise} : {s.sel_a, s.sel_b, s.rw};
  // lower lines unused in 4 bit mode; upper nibble came first
  assign code = (mp || mode_q.width8) ? s.bus : {hi_q, s.bus[7:4]};
  assign is_poll = (cls == `LCDHC_CL_POLL);
  assign accept = go & ~busy_q & ~is_poll;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_strobe_q <= 1'b0;
      prev_wr_q <= 1'b1;
      prev_rd_q <= 1'b1;
    end else if (ce) begin
      prev_strobe_q <= s.strobe;
      // strobes idle high outside muxed mode, so entering it shows no false edge
      prev_wr_q <= ~mp | (s.sel_a & s.sel_b);
      prev_rd_q <= ~mp | (s.rw & s.sel_b);
    end
  end

  // nibble phase runs even when busy so the pairing never slips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nib_q <= 1'b0;
      hi_q <= 4'h0;
    end else if (ce) begin
      if (mp || mode_q.width8) begin
        nib_q <= 1'b0;
      end else if (strobe_fall) begin
        nib_q <= ~nib_q;
        if (!nib_q) begin
          hi_q <= s.bus[7:4];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= `LCDHC_ADDR_ZERO;
    end else if (ce && mp && ale_fall) begin
      addr_q <= s.bus;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= 11'h000;
      in_q <= 8'h00;
    end else if (ce && accept) begin
      instr_q <= {cls, code};
      in_q <= code;
    end
  end

  // busy for a fixed execution time after each accepted instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LCDHC_IDLE;
      busy_q <= 1'b0;
      cnt_q <= '0;
      exec_q <= 1'b0;
    end else if (ce) begin
      exec_q <= accept;
      unique case (state_q)
        LCDHC_IDLE: begin
          if (accept) begin
            state_q <= LCDHC_RUN;
            busy_q <= 1'b1;
            cnt_q <= `LCDHC_CNT_W'(`LCDHC_EXEC_CYC - 1);
          end
        end
        LCDHC_RUN: begin
          if (cnt_q == '0) begin
            state_q <= LCDHC_IDLE;
            busy_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  logic [2:0] x_cls;
  logic [7:0] x_code;
  logic op_func, op_entry, op_disp, op_ul, op_blink, op_move, op_mark;
  logic op_wdat, op_rdat, auto_step, move_start;
  assign x_cls = instr_q[10:8];
  assign x_code = instr_q[7:0];
  assign op_func = exec_q && x_cls == `LCDHC_CL_CFG && x_code[7:6] == `LCDHC_OP_FUNC;
  assign op_entry = exec_q && x_cls == `LCDHC_CL_CFG && x_code[7:4] == `LCDHC_OP_ENTRY;
  assign op_disp = exec_q && x_cls == `LCDHC_CL_CFG && x_code[7:4] == `LCDHC_OP_DISP;
  assign op_ul = exec_q && x_cls == `LCDHC_CL_CFG && x_code[7:4] == `LCDHC_OP_UL;
  assign op_blink = exec_q && x_cls == `LCDHC_CL_CFG && x_code[7:4] == `LCDHC_OP_BLINK;
  assign op_move = exec_q && x_cls == `LCDHC_CL_CFG && x_code[7:3] == `LCDHC_OP_MOVE;
  assign op_mark = exec_q && x_cls == `LCDHC_CL_CFG && x_code[7:2] == `LCDHC_OP_MARK;
  assign op_wdat = exec_q && x_cls == `LCDHC_CL_WDAT;
  assign op_rdat = exec_q && x_cls == `LCDHC_CL_RDAT;
  assign auto_step = (op_wdat && mode_q.step_wr) || (op_rdat && mode_q.step_rd);
  assign move_start = x_code[1];

  // mode settings, kept for later execution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= lcdhc_mode_t'(`LCDHC_MODE_RST);
    end else if (ce) begin
      if (op_func) begin
        {mode_q.width8, mode_q.font, mode_q.lines, mode_q.part} <= x_code[5:0];
      end
      if (op_entry) begin
        {mode_q.step_wr, mode_q.step_rd, mode_q.step_up} <= x_code[3:1];
      end
      if (op_disp) begin
        mode_q.disp <= x_code[3:0];
      end
      if (op_ul) begin
        mode_q.ul_mode <= x_code[1:0];
      end
      if (op_blink) begin
        mode_q.blink <= x_code[3:0];
      end
    end
  end

  function automatic logic [7:0] dend(input logic [1:0] part);
    unique case (part)
      2'h0: dend = `LCDHC_DEND0;
      2'h1: dend = `LCDHC_DEND1;
      2'h2: dend = `LCDHC_DEND2;
      2'h3: dend = `LCDHC_DEND3;
    endcase
  endfunction

  // wrap inside the region holding the address; line count plays no part
  function automatic logic [7:0] step(input logic [7:0] a, input logic up,
                                      input logic [1:0] part);
    logic [7:0] e;
    e = dend(part);
    if (a <= e) begin
      if (up) begin
        step = (a == e) ? `LCDHC_ADDR_ZERO : a + 8'h01;
      end else begin
        step = (a == `LCDHC_ADDR_ZERO) ? e : a - 8'h01;
      end
    end else begin
      if (up) begin
        step = (a == `LCDHC_RAM_TOP) ? e + 8'h01 : a + 8'h01;
      end else begin
        step = (a == e + 8'h01) ? `LCDHC_RAM_TOP : a - 8'h01;
      end
    end
  endfunction

  logic apb_wr;
  assign apb_wr = psel & penable & pwrite & pready_q;

  // auto step one cycle late, so the ram write still sees the old address
  logic step_pend_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cursor_q <= `LCDHC_ADDR_ZERO;
      step_pend_q <= 1'b0;
    end else if (ce) begin
      step_pend_q <= auto_step;
      if (exec_q && x_cls == `LCDHC_CL_WCUR) begin
        cursor_q <= in_q;
      end else if (op_move && !move_start) begin
        cursor_q <= step(cursor_q, x_code[0], mode_q.part);
      end else if (step_pend_q) begin
        cursor_q <= step(cursor_q, mode_q.step_up, mode_q.part);
      end else if (apb_wr && paddr == `LCDHC_A_CURSOR) begin
        cursor_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= `LCDHC_ADDR_ZERO;
    end else if (ce) begin
      if (exec_q && x_cls == `LCDHC_CL_WSTA) begin
        start_q <= in_q;
      end else if (op_move && move_start) begin
        start_q <= step(start_q, x_code[0], mode_q.part);
      end
    end
  end

  // own ram port, so refresh elsewhere never waits on the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_we_q <= 1'b0;
      ram_ul_we_q <= 1'b0;
      ram_ul_bit_q <= 1'b0;
      ram_wdata_q <= 8'h00;
    end else if (ce) begin
      ram_we_q <= op_wdat;
      ram_ul_we_q <= op_mark;
      if (op_wdat) begin
        ram_wdata_q <= in_q;
      end
      if (op_mark) begin
        ram_ul_bit_q <= in_q[1];
      end
    end
  end

  // read results kept ready; ram data refreshed once the cursor settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
    end else if (ce && !busy_q && !ram_we_q) begin
      rdata_q <= ram_rdata;
    end
  end

  logic [2:0] rd_cls;
  logic rd_window;
  logic [7:0] rd_val;
  assign rd_cls = mp ? {addr_q[1:0], 1'b1} : {s.sel_a, s.sel_b, s.rw};
  assign rd_window = mp ? (~s.rw & s.sel_b) : (s.strobe & s.rw);
  always_comb begin
    unique case (rd_cls)
      `LCDHC_CL_POLL: rd_val = {busy_q, 3'h0, busy_q, 3'h0};
      `LCDHC_CL_RCUR: rd_val = cursor_q;
      `LCDHC_CL_RSTA: rd_val = start_q;
      `LCDHC_CL_RDAT: rd_val = rdata_q;
      default: rd_val = 8'h00;
    endcase
  end

  // bus driven only while the host reads; 4 bit mode sends high nibble first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 8'h00;
      oe_q <= 2'b00;
    end else if (ce) begin
      if (mp || mode_q.width8) begin
        out_q <= rd_val;
        oe_q <= {rd_window, rd_window};
      end else begin
        out_q <= {nib_q ? rd_val[3:0] : rd_val[7:4], 4'h0};
        oe_q <= {rd_window, 1'b0};
      end
    end
  end

  // apb slave: one wait state, pslverr on unmapped
  logic mapped;
  logic [31:0] rmux;
  assign mapped = paddr == `LCDHC_A_STATUS || paddr == `LCDHC_A_MODE ||
                  paddr == `LCDHC_A_CURSOR || paddr == `LCDHC_A_CTRL ||
                  paddr == `LCDHC_A_START;
  always_comb begin
    unique case (paddr)
      `LCDHC_A_STATUS: rmux = {29'h0, nib_q, mode_q.width8, busy_q};
      `LCDHC_A_MODE: rmux = {12'h0, 20'(mode_q)};
      `LCDHC_A_CURSOR: rmux = {24'h0, cursor_q};
      `LCDHC_A_CTRL: rmux = {31'h0, host_en_q};
      `LCDHC_A_START: rmux = {24'h0, start_q};
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce) begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? rmux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_en_q <= 1'b1;
    end else if (ce && apb_wr && paddr == `LCDHC_A_CTRL) begin
      host_en_q <= pwdata[0];
    end
  end

  assign host_bus_out = out_q;
  assign host_bus_oe = oe_q;
  assign busy = busy_q;
  assign mode = mode_q;
  assign ram_addr = cursor_q;
  assign ram_wdata = ram_wdata_q;
  assign ram_we = ram_we_q;
  assign ram_ul_we = ram_ul_we_q;
  assign ram_ul_bit = ram_ul_bit_q;
  assign disp_start = start_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  busy_hold_a: assert property (accept |=> busy_q [*8] ##1 !busy_q)
    else $error("busy not held for execution time");
  busy_ignore_a: assert property (go && busy_q |=> $stable(instr_q))
    else $error("instruction taken while busy");
  poll_flag_a: assert property (rd_window && rd_cls == `LCDHC_CL_POLL && (mp || mode_q.width8)
    |=> host_bus_out[7] == $past(busy_q) && host_bus_out[3] == $past(busy_q))
    else $error("busy flag not on bits 7 and 3");
  cursor_load_a: assert property (exec_q && x_cls == `LCDHC_CL_WCUR
    |=> cursor_q == $past(in_q))
    else $error("cursor load lost");
  disp_wrap_a: assert property (op_move && !move_start && x_code[0]
    && cursor_q == dend(mode_q.part) |=> cursor_q == 8'h00)
    else $error("display region did not wrap");
  glyph_wrap_a: assert property (op_move && !move_start && !x_code[0]
    && cursor_q == dend(mode_q.part) + 8'h01 |=> cursor_q == 8'hff)
    else $error("glyph region did not wrap");
  nibble_pair_a: assert property (!mp && !mode_q.width8 && strobe_fall && !nib_q
    |=> nib_q && !exec_q)
    else $error("first nibble executed");
  width_set_a: assert property (op_func |=> mode_q.width8 == $past(x_code[5]))
    else $error("width not stored");
  ram_write_a: assert property (op_wdat |=> ram_we && ram_addr == $past(cursor_q))
    else $error("ram write not at cursor");
  step_up_a: assert property (op_wdat && mode_q.step_wr && mode_q.step_up
    && cursor_q < dend(mode_q.part) |=> ##1 cursor_q == $past(cursor_q, 2) + 8'h01)
    else $error("auto step missing");
  no_step_a: assert property (op_wdat && !mode_q.step_wr
    |=> $stable(cursor_q) ##1 $stable(cursor_q))
    else $error("unexpected auto step");
  apb_ready_a: assert property (psel && penable && !pready_q |=> pready_q)
    else $error("apb answer late");

  nib_cmd_c: cover property (uc_go && !mode_q.width8 && accept);
  poll_busy_c: cover property (go && busy_q && is_poll);
  glyph_wrap_c: cover property (auto_step && cursor_q == `LCDHC_RAM_TOP);
  mp_write_c: cover property (mp_go && wr_rise && accept);
endmodule // lcdhc_top

/* lcdhc_host_model.sv */
// host controller model driving the front end pins
`timescale 1ns/1ps
`include "lcdhc_params.svh"
module lcdhc_host_model (
  input wire logic pclk,
  input wire logic wide,
  input wire logic [7:0] host_bus_out,
  input wire logic [1:0] host_bus_oe,
  output lcdhc_pkg::lcdhc_pins_t host_pins
);
  import lcdhc_pkg::*;
  lcdhc_pins_t p;
  logic [7:0] drv;
  logic [7:0] junk;
  logic drv_en;
  initial begin
    p = '0;
    drv = '0;
    drv_en = 1'b0;
    junk = '0;
  end
  // released lines wander so a stale value never reads as valid
  always @(posedge pclk) junk <= junk + 8'h35;
  always_comb begin
    host_pins = p;
    host_pins.bus[7:4] = host_bus_oe[1] ? host_bus_out[7:4] : drv_en ? drv[7:4] : junk[7:4];
    host_pins.bus[3:0] = host_bus_oe[0] ? host_bus_out[3:0] : drv_en ? drv[3:0] : junk[3:0];
  end
  // one strobe pass; reads keep the strobe up longer for the synced output
  task automatic pass(input logic [2:0] cls, input logic [7:0] d, output logic [7:0] q);
    @(posedge pclk);
    {p.sel_a, p.sel_b, p.rw} <= cls;
    p.strobe <= 1'b1;
    drv <= d;
    drv_en <= ~cls[0];
    repeat (cls[0] ? 6 : 3) @(posedge pclk);
    q = host_pins.bus;
    p.strobe <= 1'b0;
    repeat (3) @(posedge pclk);
    drv_en <= 1'b0;
  endtask
  task automatic xfer(input logic [2:0] cls, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] a;
    if (wide) pass(cls, d, q);
    else begin
      pass(cls, {d[7:4], 4'($urandom)}, a);
      pass(cls, {d[3:0], 4'($urandom)}, q);
      q = {a[7:4], q[7:4]};
    end
  endtask
  task automatic cmd(input logic [2:0] cls, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] s;
    s = 8'h88;
    while (s[7]) xfer(`LCDHC_CL_POLL, 8'h00, s);
    xfer(cls, d, q);
  endtask
  // muxed bus write: address on the latch strobe, data on the write strobe
  task automatic mux_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    p <= '{host_type: 1'b1, sel_a: 1'b1, sel_b: 1'b1, rw: 1'b1, strobe: 1'b1, bus: 8'h00};
    drv <= a;
    drv_en <= 1'b1;
    repeat (3) @(posedge pclk);
    p.strobe <= 1'b0;
    repeat (3) @(posedge pclk);
    p.sel_a <= 1'b0;
    drv <= d;
    repeat (3) @(posedge pclk);
    p.sel_a <= 1'b1;
    repeat (3) @(posedge pclk);
    drv_en <= 1'b0;
    p <= '0;
  endtask
endmodule // lcdhc_host_model

/* lcd_host_cmd_cursor_bench.sv */
// self-checking bench for the lcd host command front end
`timescale 1ns/1ps
`include "lcdhc_params.svh"
module lcd_host_cmd_cursor_bench;
  import lcdhc_pkg::*;
  logic pclk, presetn, ce, busy, ram_we, ram_ul_we, ram_ul_bit, ul_seen;
  logic psel, penable, pwrite, pready, pslverr, e, up, wide8;
  logic [7:0] host_bus_out, ram_addr, ram_wdata, ram_rdata, disp_start, paddr, q, a, d, we_data;
  logic [1:0] host_bus_oe;
  logic [31:0] pwdata, prdata, r;
  lcdhc_pins_t host_pins;
  lcdhc_mode_t mode;
  int n_errors = 0, num_checks = 0, n_we = 0, n_ul = 0, m;
  lcdhc_top lcdhc_top_i (.pclk, .presetn, .ce, .host_pins, .host_bus_out, .host_bus_oe, .busy,
    .mode, .ram_addr, .ram_wdata, .ram_we, .ram_ul_we, .ram_ul_bit, .ram_rdata, .disp_start,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  lcdhc_host_model lcdhc_host_model_i (.pclk(pclk), .wide(wide8),
    .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .host_pins(host_pins));
  // ram content is a fixed function of its address
  always @(posedge pclk) begin
    ram_rdata <= ram_addr ^ 8'h5a;
    if (ram_we === 1'b1) begin
      n_we <= n_we + 1;
      we_data <= ram_wdata;
    end
    if (ram_ul_we === 1'b1) begin
      n_ul <= n_ul + 1;
      ul_seen <= ram_ul_bit;
    end
  end
  task automatic check(input logic [31:0] s, input logic [31:0] x, input string msg);
    num_checks++;
    if (s !== x) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h exp %h", $time, msg, s, x);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [7:0] v);
    lcdhc_host_model_i.cmd(c, v, q);
  endtask
  // next cursor value inside the region holding the address
  function automatic logic [7:0] nxt(input logic [7:0] ad, input logic u, input logic [1:0] pt);
    logic [7:0] top, lo, hi;
    top = 8'hff - {1'b0, pt, 5'h00};
    lo = (ad <= top) ? 8'h00 : top + 8'h01;
    hi = (ad <= top) ? top : 8'hff;
    if (u) return (ad == hi) ? lo : ad + 8'h01;
    return (ad == lo) ? hi : ad - 8'h01;
  endfunction
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    end_sim;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    wide8 = 1'b1;
    void'($urandom(32'hb13fdc9a));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(mode), 32'(`LCDHC_MODE_RST), "mode at reset");
    check(32'(busy), 32'h0, "busy at reset");
    apb(1'b0, `LCDHC_A_STATUS, 32'h0);
    check(r, 32'h2, "status");
    apb(1'b1, `LCDHC_A_CURSOR, 32'h3c);
    apb(1'b1, `LCDHC_A_START, 32'h55);
    apb(1'b0, `LCDHC_A_START, 32'h0);
    check(r, 32'h0, "start is read only");
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, e}, 32'h1, "unmapped error");
    apb(1'b1, `LCDHC_A_CTRL, 32'h0);
    lcdhc_host_model_i.xfer(`LCDHC_CL_WCUR, 8'h11, q);
    apb(1'b1, `LCDHC_A_CTRL, 32'h1);
    check(32'(ram_addr), 32'h3c, "disabled host ignored");
    // second instruction lands while busy and must leave no trace
    cmd(`LCDHC_CL_WDAT, 8'h77);
    lcdhc_host_model_i.xfer(`LCDHC_CL_WCUR, 8'h11, q);
    cmd(`LCDHC_CL_WDAT, 8'h78);
    lcdhc_host_model_i.xfer(`LCDHC_CL_POLL, 8'h00, q);
    check(32'(q), 32'h88, "poll while busy");
    cmd(`LCDHC_CL_RCUR, 8'h00);
    check(32'(q), 32'h3c, "cursor after refused load");
    check(32'(we_data), 32'h78, "written data");
    check(n_we, 2, "write pulses");
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      cmd(`LCDHC_CL_CFG, {4'h3, d[3:0]});
      cmd(`LCDHC_CL_CFG, {6'h08, d[5:4]});
      cmd(`LCDHC_CL_CFG, {4'h1, d[7:4]});
      cmd(`LCDHC_CL_POLL, 8'h00);
      check(32'({mode.disp, mode.ul_mode, mode.blink}), 32'({d[3:0], d[5:4], d[7:4]}), "modes");
    end
    for (int pt = 0; pt < 4; pt++) begin
      cmd(`LCDHC_CL_CFG, {4'he, 2'($urandom), 2'(pt)});
      for (int k = 0; k < 8; k++) begin
        up = 1'($urandom);
        m = k % 4;
        a = nxt(8'h00, 1'b0, 2'(pt));
        a = (k == 0) ? 8'h00 : (k == 1 || k == 4) ? a : (k == 2) ? a + 8'h01 :
            (k == 3) ? 8'hff : 8'($urandom);
        d = 8'($urandom);
        cmd(`LCDHC_CL_CFG, {4'h4, m == 1, m >= 2, up, 1'b0});
        cmd(`LCDHC_CL_WCUR, a);
        case (m)
          0: cmd(`LCDHC_CL_CFG, {7'h04, up});
          2: cmd(`LCDHC_CL_RDAT, 8'h00);
          default: cmd(`LCDHC_CL_WDAT, d);
        endcase
        if (m == 2) check(32'(q), 32'(a ^ 8'h5a), "ram read");
        cmd(`LCDHC_CL_RCUR, 8'h00);
        if (m == 1 || m == 3) check(32'(we_data), 32'(d), "ram write");
        check(32'(q), 32'((m == 3) ? a : nxt(a, up, 2'(pt))), "cursor step");
      end
    end
    cmd(`LCDHC_CL_CFG, 8'h06);
    cmd(`LCDHC_CL_WSTA, 8'h42);
    cmd(`LCDHC_CL_RSTA, 8'h00);
    check(32'(q), 32'h42, "start fetch");
    cmd(`LCDHC_CL_CFG, 8'h0b);
    cmd(`LCDHC_CL_RSTA, 8'h00);
    check(32'(q), 32'h43, "start step");
    check(32'(disp_start), 32'h43, "start output");
    check(n_ul, 1, "underline pulses");
    check(32'(ul_seen), 32'h1, "underline mark");
    cmd(`LCDHC_CL_CFG, 8'hc3);
    // host switches to nibble passes once it has sent the width change
    wide8 = 1'b0;
    cmd(`LCDHC_CL_WCUR, 8'ha7);
    cmd(`LCDHC_CL_RCUR, 8'h00);
    check(32'({mode.width8, q}), 32'h0a7, "nibble cursor");
    cmd(`LCDHC_CL_CFG, 8'he3);
    wide8 = 1'b1;
    cmd(`LCDHC_CL_POLL, 8'h00);
    lcdhc_host_model_i.mux_wr(8'h01, 8'h5c);
    repeat (12) @(posedge pclk);
    check(32'({mode.width8, ram_addr}), 32'h15c, "muxed bus load");
    end_sim;
  end
endmodule // lcd_host_cmd_cursor_bench
